// ---- rtl/cfd_consts.svh ----
/*
  Constants of the condition and field decoder: flag positions, field codes,
  opcode groups and register offsets.
  Assumes inclusion by the package and the decoder module only.
*/
`ifndef CFD_CONSTS_SVH
`define CFD_CONSTS_SVH

// ------------------------------------------------------------------
// Flag positions in the 4-bit condition flag field
// ------------------------------------------------------------------
`define FLAG_C          0
`define FLAG_V          1
`define FLAG_Z          2
`define FLAG_N          3

// ------------------------------------------------------------------
// Opcode groups (bits 15..12)
// ------------------------------------------------------------------
`define GRP_IMM_BIT     4'h0
`define GRP_COND_MISC   4'h5
`define GRP_BRANCH      4'h6
`define GRP_UNASSIGNED  4'hA
`define GRP_COPROC      4'hF

// ------------------------------------------------------------------
// Field codes
// ------------------------------------------------------------------
`define COND_ALWAYS     4'h0
`define COND_NEVER      4'h1
`define SZ_BYTE         2'h0
`define SZ_WORD         2'h1
`define SZ_LONG         2'h2
`define SZ_NONE         2'h3
`define XFER_NONE       3'h0
`define XFER_W_TO_REG   3'h4
`define XFER_L_TO_REG   3'h5
`define XFER_W_TO_MEM   3'h6
`define XFER_L_TO_MEM   3'h7
`define EA_MODE_EXT     3'h7
`define EA_MODE_ADDR    3'h1
`define IMM_STATIC_BIT  3'h4
`define IMM_RESERVED    3'h7
`define BOUNDS_TAG      3'h3
`define CP_BRANCH_TAG   2'h1

// ------------------------------------------------------------------
// APB register map (byte addresses) and reset values
// ------------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_COUNT       8'h08
`define CTRL_RESET      2'h3
`define CTRL_DEC_EN     0
`define CTRL_CP_EN      1

`endif

// ---- rtl/cfd_pkg.sv ----
/*
  Types of the condition and field decoder.
  Assumes cfd_consts.svh is on the include path.
*/
`include "cfd_consts.svh"

package cfd_pkg;

  typedef enum logic [3:0] {
    cond_always                 = `COND_ALWAYS,
    cond_never                  = `COND_NEVER,
    cond_unsigned_higher        = 4'h2,
    cond_unsigned_lower_or_same = 4'h3,
    cond_carry_clear            = 4'h4,
    cond_carry_set              = 4'h5,
    cond_not_equal              = 4'h6,
    cond_equal                  = 4'h7,
    cond_overflow_clear         = 4'h8,
    cond_overflow_set           = 4'h9,
    cond_plus                   = 4'hA,
    cond_minus                  = 4'hB,
    cond_signed_ge              = 4'hC,
    cond_signed_less            = 4'hD,
    cond_signed_greater         = 4'hE,
    cond_signed_le              = 4'hF
  } cond_t;

  typedef enum logic [1:0] {
    size_byte = `SZ_BYTE,
    size_word = `SZ_WORD,
    size_long = `SZ_LONG,
    size_none = `SZ_NONE
  } size_t;

  typedef enum logic [1:0] {
    bit_test_op   = 2'h0,
    bit_toggle_op = 2'h1,
    bit_clear_op  = 2'h2,
    bit_set_op    = 2'h3
  } bit_op_t;

  typedef enum logic [2:0] {
    transfer_none       = `XFER_NONE,
    transfer_word_to_reg = `XFER_W_TO_REG,
    transfer_long_to_reg = `XFER_L_TO_REG,
    transfer_word_to_mem = `XFER_W_TO_MEM,
    transfer_long_to_mem = `XFER_L_TO_MEM
  } transfer_direction_field_t;

  typedef enum logic [3:0] {
    ea_data_reg    = 4'h0,
    ea_addr_reg    = 4'h1,
    ea_indirect    = 4'h2,
    ea_postinc     = 4'h3,
    ea_predec      = 4'h4,
    ea_disp        = 4'h5,
    ea_indexed     = 4'h6,
    ea_abs_short   = 4'h7,
    ea_abs_long    = 4'h8,
    ea_pc_disp     = 4'h9,
    ea_pc_index    = 4'hA,
    ea_immediate   = 4'hB,
    ea_invalid     = 4'hC
  } ea_kind_t;

  typedef struct packed {
    logic                      valid;
    logic                      cond_true;
    logic                      cond_illegal;
    logic [3:0]                group;
    logic                      route_coproc;
    logic                      unassigned;
    logic                      size_valid;
    size_t                     size;
    logic                      bit_valid;
    bit_op_t                   bit_op;
    logic                      xfer_valid;
    transfer_direction_field_t xfer;
    ea_kind_t                  ea_kind;
    logic [2:0]                ea_reg;
  } decode_t;

endpackage : cfd_pkg

// ---- rtl/condition_and_field_decoder.sv ----
/*
  Condition and field decoder: evaluates condition codes against the flags
  and decodes the size, bit-operation, transfer and addressing fields of a
  first instruction word, with an APB slave for control and status.
  Assumes opcode words and flags come from logic on clk_sys_in.
*/
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "cfd_consts.svh"

// Operation
// - Codes 1100..1111 compare N with V, greater-than and less-or-equal forms also use Z.
// - Code 0000 always true, 0001 false; illegal in branch and coproc branch.
// - Immediate and bounds size field: 00 byte, 01 word, 10 long.
// - Dynamic bit type field: 00 test, 01 change, 10 clear, 11 set.
// - Transfer mode 100..111: word/long, memory-to-register or register-to-memory.
// - Bits 15..12 select group; 1111 goes to coprocessor, 1010 unassigned. The code routes 1111 only while CTRL_CP_EN is set, else marks it unassigned.
// - Mode 111 uses register field for absolute, PC-relative or immediate.
module condition_and_field_decoder
  import cfd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Fetch pipeline
  input  wire logic        op_valid_in,
  input  wire logic [15:0] op_word_in,
  input  wire logic [3:0]  flags_in,
  // Execution control
  output var decode_t      dec_out,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out
);

  // ------------------------------------------------------------------
  // Field extraction
  // ------------------------------------------------------------------
  logic [1:0]  ctrl;
  logic [31:0] count;
  logic [3:0]  group;
  logic [2:0]  ea_mode;
  logic [2:0]  ea_reg;
  logic        is_cp_branch;
  logic        is_grp0;
  logic [3:0]  code;
  logic        fn;
  logic        fz;
  logic        fv;
  logic        fc;
  logic        fire;
  decode_t     next_dec;

  assign group        = op_word_in[15:12];
  assign ea_mode      = op_word_in[5:3];
  assign ea_reg       = op_word_in[2:0];
  assign is_grp0      = (group == `GRP_IMM_BIT);
  assign is_cp_branch = (group == `GRP_COPROC) && (op_word_in[8:7] == `CP_BRANCH_TAG);
  assign code         = is_cp_branch ? op_word_in[3:0] : op_word_in[11:8];
  assign fn           = flags_in[`FLAG_N];
  assign fz           = flags_in[`FLAG_Z];
  assign fv           = flags_in[`FLAG_V];
  assign fc           = flags_in[`FLAG_C];
  assign fire         = op_valid_in && ctrl[`CTRL_DEC_EN];

  // ------------------------------------------------------------------
  // Condition evaluation
  // ------------------------------------------------------------------
  function automatic logic cond_eval(input logic [3:0] c, input logic n,
                                     input logic z, input logic v, input logic k);
    logic r;
    r = 1'b0;
    case (cond_t'(c))
      cond_always:                 r = 1'b1;
      cond_never:                  r = 1'b0;
      cond_unsigned_higher:        r = !k && !z;
      cond_unsigned_lower_or_same: r = k || z;
      cond_carry_clear:            r = !k;
      cond_carry_set:              r = k;
      cond_not_equal:              r = !z;
      cond_equal:                  r = z;
      cond_overflow_clear:         r = !v;
      cond_overflow_set:           r = v;
      cond_plus:                   r = !n;
      cond_minus:                  r = n;
      cond_signed_ge:              r = (n == v);
      cond_signed_less:            r = (n != v);
      cond_signed_greater:         r = (n == v) && !z;
      cond_signed_le:              r = z || (n != v);
      default:                     r = 1'b0;
    endcase
    return r;
  endfunction : cond_eval

  // ------------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------------
  always_comb begin
    next_dec              = '0;
    next_dec.valid        = fire;
    next_dec.group        = group;
    next_dec.cond_true    = cond_eval(code, fn, fz, fv, fc);
    next_dec.cond_illegal = ((group == `GRP_BRANCH) || is_cp_branch) &&
                            (code[3:1] == 3'h0);
    next_dec.route_coproc = (group == `GRP_COPROC) && ctrl[`CTRL_CP_EN];
    next_dec.unassigned   = (group == `GRP_UNASSIGNED) ||
                            ((group == `GRP_COPROC) && !ctrl[`CTRL_CP_EN]);
    next_dec.size         = size_none;
    next_dec.bit_op       = bit_test_op;
    next_dec.xfer         = transfer_none;
    if (is_grp0 && !op_word_in[8] && (op_word_in[11:9] != `IMM_STATIC_BIT) &&
        (op_word_in[11:9] != `IMM_RESERVED) && (op_word_in[7:6] != `SZ_NONE)) begin
      next_dec.size_valid = 1'b1;
      next_dec.size       = size_t'(op_word_in[7:6]);
    end else if (is_grp0 && !op_word_in[11] && (op_word_in[8:6] == `BOUNDS_TAG) &&
                 (op_word_in[10:9] != `SZ_NONE)) begin
      next_dec.size_valid = 1'b1;
      next_dec.size       = size_t'(op_word_in[10:9]);
    end
    if (is_grp0 && op_word_in[8]) begin
      if (ea_mode == `EA_MODE_ADDR) begin
        next_dec.xfer_valid = 1'b1;
        next_dec.xfer       = transfer_direction_field_t'(op_word_in[8:6]);
      end else begin
        next_dec.bit_valid  = 1'b1;
        next_dec.bit_op     = bit_op_t'(op_word_in[7:6]);
      end
    end
    next_dec.ea_reg = ea_reg;
    if (ea_mode != `EA_MODE_EXT) begin
      next_dec.ea_kind = ea_kind_t'({1'b0, ea_mode});
    end else begin
      case (ea_reg)
        3'h0:    next_dec.ea_kind = ea_abs_short;
        3'h1:    next_dec.ea_kind = ea_abs_long;
        3'h2:    next_dec.ea_kind = ea_pc_disp;
        3'h3:    next_dec.ea_kind = ea_pc_index;
        3'h4:    next_dec.ea_kind = ea_immediate;
        default: next_dec.ea_kind = ea_invalid;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Decode output register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      dec_out <= '0;
    end else begin
      dec_out <= next_dec;
    end
  end

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  logic apb_take;
  logic apb_done;
  logic addr_ok;

  assign apb_take = psel_in && penable_in && !pready_out;
  assign apb_done = psel_in && penable_in && pready_out;
  assign addr_ok  = (paddr_in == `REG_CTRL) || (paddr_in == `REG_STATUS) ||
                    (paddr_in == `REG_COUNT);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= apb_take;
      pslverr_out <= apb_take && !addr_ok;
      prdata_out  <= 32'h0000_0000;
      if (apb_take && !pwrite_in) begin
        case (paddr_in)
          `REG_CTRL:   prdata_out <= {30'h0000_0000, ctrl};
          `REG_STATUS: prdata_out <= {{(32 - $bits(decode_t)){1'b0}}, dec_out};
          `REG_COUNT:  prdata_out <= count;
          default:     prdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control: decode enable and coprocessor routing enable
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl <= `CTRL_RESET;
    end else if (apb_done && pwrite_in && (paddr_in == `REG_CTRL)) begin
      ctrl <= pwdata_in[1:0];
    end
  end

  // Decoded word counter; a count in the clearing cycle is kept
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      count <= 32'h0000_0000;
    end else if (apb_done && pwrite_in && (paddr_in == `REG_COUNT)) begin
      count <= fire ? 32'h0000_0001 : 32'h0000_0000;
    end else if (fire) begin
      count <= count + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  property p_cond_ge_lt;
    fire && (group == `GRP_BRANCH) && (op_word_in[11:9] == 3'h6) |=>
      dec_out.cond_true == ($past(op_word_in[8]) ? ($past(fn) != $past(fv))
                                                 : ($past(fn) == $past(fv)));
  endproperty
  a_cond_ge_lt: assert property (p_cond_ge_lt) else $error("ge/lt wrong");

  property p_cond_le;
    fire && (group == `GRP_COND_MISC) && (op_word_in[11:8] == 4'hF) |=>
      dec_out.cond_true == ($past(fz) || ($past(fn) != $past(fv)));
  endproperty
  a_cond_le: assert property (p_cond_le) else $error("le wrong");

  property p_true_false;
    fire && (group == `GRP_BRANCH) && (op_word_in[11:9] == 3'h0) |=>
      dec_out.cond_illegal && (dec_out.cond_true == !$past(op_word_in[8]));
  endproperty
  a_true_false: assert property (p_true_false) else $error("t/f code wrong");

  property p_size;
    fire && (op_word_in[15:8] == 8'h06) && (op_word_in[7:6] == 2'h2) |=>
      dec_out.size_valid && (dec_out.size == size_long) && dec_out.valid;
  endproperty
  a_size: assert property (p_size) else $error("size decode wrong");

  property p_bit_op;
    fire && is_grp0 && op_word_in[8] && (ea_mode != `EA_MODE_ADDR) |=>
      dec_out.bit_valid && !dec_out.xfer_valid &&
      (dec_out.bit_op == $past(op_word_in[7:6]));
  endproperty
  a_bit_op: assert property (p_bit_op) else $error("bit op wrong");

  property p_xfer;
    fire && is_grp0 && op_word_in[8] && (ea_mode == `EA_MODE_ADDR) |=>
      dec_out.xfer_valid && (dec_out.xfer == $past(op_word_in[8:6]));
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer mode wrong");

  property p_group;
    fire && (group == `GRP_UNASSIGNED) |=>
      dec_out.unassigned && !dec_out.route_coproc && (dec_out.group == `GRP_UNASSIGNED);
  endproperty
  a_group: assert property (p_group) else $error("group routing wrong");

  property p_ea_ext;
    fire && (ea_mode == `EA_MODE_EXT) && (ea_reg == 3'h4) |=>
      dec_out.ea_kind == ea_immediate;
  endproperty
  a_ea_ext: assert property (p_ea_ext) else $error("ea ext wrong");

  property p_cond_hi;
    fire && (group == `GRP_COND_MISC) && (op_word_in[11:8] == 4'h2) |=>
      dec_out.cond_true == (!$past(fc) && !$past(fz));
  endproperty
  a_cond_hi: assert property (p_cond_hi) else $error("hi wrong");

  property p_cp_illegal;
    fire && is_cp_branch && (code[3:1] == 3'h0) |=>
      dec_out.cond_illegal && (dec_out.cond_true == !$past(code[0]));
  endproperty
  a_cp_illegal: assert property (p_cp_illegal) else $error("coproc t/f code wrong");

  property p_coproc_route;
    fire && (group == `GRP_COPROC) |=>
      (dec_out.route_coproc == $past(ctrl[`CTRL_CP_EN])) &&
      (dec_out.unassigned == !$past(ctrl[`CTRL_CP_EN]));
  endproperty
  a_coproc_route: assert property (p_coproc_route) else $error("coproc routing wrong");

  property p_count;
    fire && !(apb_done && pwrite_in && (paddr_in == `REG_COUNT)) |=>
      count == $past(count) + 32'h0000_0001;
  endproperty
  a_count: assert property (p_count) else $error("count did not advance");

  property p_apb_answer;
    apb_take |=> pready_out && (pslverr_out == !$past(addr_ok)) ##1 !pready_out;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer wrong");

  c_coproc: cover property (fire && (group == `GRP_COPROC) ##1 dec_out.route_coproc);
  c_illegal: cover property (fire ##1 dec_out.cond_illegal);
  c_apb_err: cover property (apb_done && pslverr_out);
  c_ge_lt: cover property (fire && (group == `GRP_BRANCH) && (op_word_in[11:9] == 3'h6));
  c_xfer: cover property (fire && is_grp0 && op_word_in[8] && (ea_mode == `EA_MODE_ADDR));

endmodule : condition_and_field_decoder
`default_nettype wire

// ---- verif/fetch_model.sv ----
/*
  Fetch pipeline model: presents queued opcode words, one per cycle.
  Assumes one clock shared with the decoder; the bench fills the queue.
*/
`timescale 1ns/1ns
`default_nettype none
module fetch_model (
  // Clock
  input  wire logic        clk_in,
  // Opcode stream
  output logic             op_valid_out = 1'b0,
  output logic [15:0]      op_word_out = 16'h0000,
  output logic [3:0]       flags_out = 4'h0
);
  logic [19:0] pend[$];

  // ------------------------------------------------------------------
  // Queue access
  // ------------------------------------------------------------------
  task automatic push(input logic [15:0] w, input logic [3:0] f);
    pend.push_back({w, f});
  endtask : push

  function automatic int depth();
    return pend.size();
  endfunction : depth

  // Idle cycles alternate between the inverse of the last word and the last word
  always @(posedge clk_in) begin
    if (pend.size() != 0) begin
      {op_word_out, flags_out} <= pend.pop_front();
      op_valid_out             <= 1'b1;
    end else begin
      op_word_out  <= ~op_word_out;
      flags_out    <= ~flags_out;
      op_valid_out <= 1'b0;
    end
  end
endmodule : fetch_model
`default_nettype wire

// ---- verif/tb.sv ----
/*
  Self-checking bench of the condition and field decoder.
  Assumes cfd_pkg compiled first and fetch_model as the opcode source.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import cfd_pkg::*;
  typedef struct packed {logic chk_d; logic err; logic [31:0] d;} apb_exp_t;
  logic        clk_sys_in, rst_in, psel, penable, pwrite, pready, pslverr, op_valid, vq, st_rd;
  decode_t     dec_hold;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed, count_exp, r;
  logic [15:0] op_word;
  logic [3:0]  flags;
  logic [1:0]  ctrl;
  decode_t     dec;
  apb_exp_t    a;
  decode_t     dq[$];
  apb_exp_t    aq[$];
  int          mismatches, tests_run;
  logic [15:0] fw[23] = '{16'h0080, 16'h00C0, 16'h04C0, 16'h0280, 16'h0A40, 16'h0800,
    16'h0100, 16'h0140, 16'h0180, 16'h01C0, 16'h0108, 16'h0148, 16'h0188, 16'h01C8,
    16'h003C, 16'h0038, 16'h0039, 16'h003A, 16'h003B, 16'h003D, 16'h0680, 16'hA000, 16'hF000};

  condition_and_field_decoder uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .op_valid_in(op_valid), .op_word_in(op_word), .flags_in(flags), .dec_out(dec),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));
  fetch_model fetch (.clk_in(clk_sys_in), .op_valid_out(op_valid), .op_word_out(op_word),
    .flags_out(flags));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic decode_t exp_dec(input logic [15:0] w, input logic [3:0] f);
    decode_t     e;
    logic        cp, x;
    logic [3:0]  cc;
    logic [15:0] t;
    e = '0;
    x = f[3] ^ f[1];
    t = {f[2] | x, ~f[2] & ~x, x, ~x, f[3], ~f[3], f[1], ~f[1], f[2], ~f[2], f[0], ~f[0],
         f[0] | f[2], ~f[0] & ~f[2], 2'b01};
    cp = (w[15:12] == 4'hF) && (w[8:7] == 2'b01);
    cc = cp ? w[3:0] : w[11:8];
    e.valid = ctrl[0];
    e.cond_true = t[cc];
    e.cond_illegal = (cc < 4'h2) && (cp || w[15:12] == 4'h6);
    e.group = w[15:12];
    e.route_coproc = (w[15:12] == 4'hF) && ctrl[1];
    e.unassigned = (w[15:12] == 4'hA) || (w[15:12] == 4'hF && !ctrl[1]);
    e.size = size_none;
    if (w[15:12] == 4'h0 && !w[8] && w[11:9] != 3'b100 && w[11:9] != 3'b111 &&
        w[7:6] != 2'b11) begin
      e.size_valid = 1'b1;
      e.size = size_t'(w[7:6]);
    end else if (w[15:12] == 4'h0 && w[11:6] ==? 6'b0??011 && w[10:9] != 2'b11) begin
      e.size_valid = 1'b1;
      e.size = size_t'(w[10:9]);
    end
    if (w[15:12] == 4'h0 && w[8] && w[5:3] == 3'b001) begin
      e.xfer_valid = 1'b1;
      e.xfer = transfer_direction_field_t'(w[8:6]);
    end else if (w[15:12] == 4'h0 && w[8]) begin
      e.bit_valid = 1'b1;
      e.bit_op = bit_op_t'(w[7:6]);
    end
    e.ea_kind = (w[5:3] != 3'h7) ? ea_kind_t'({1'b0, w[5:3]}) :
                (w[2:0] < 3'h5) ? ea_kind_t'(4'h7 + {1'b0, w[2:0]}) : ea_invalid;
    e.ea_reg = w[2:0];
    return e;
  endfunction : exp_dec

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic chk_dec(input decode_t e, input decode_t g);
    if (!e.bit_valid) begin
      e.bit_op = bit_test_op;
      g.bit_op = bit_test_op;
    end
    if (!e.xfer_valid) begin
      e.xfer = transfer_none;
      g.xfer = transfer_none;
    end
    chk("dec_out", 32'(e), 32'(g));
  endtask : chk_dec

  task automatic send(input logic [15:0] w, input logic [3:0] f);
    fetch.push(w, f);
    dq.push_back(exp_dec(w, f));
    count_exp = count_exp + 32'(ctrl[0]);
  endtask : send

  task automatic drain();
    int n;
    n = 0;
    while (fetch.depth() != 0 && n < 2000) begin
      @(posedge clk_sys_in);
      n++;
    end
    repeat (3) @(posedge clk_sys_in);
  endtask : drain

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     input apb_exp_t e);
    int n;
    aq.push_back(e);
    st_rd = !w && (ad == 8'h04);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk("pready", 32'h1, 32'(pready));
  endtask : apb

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // ------------------------------------------------------------------
  // Result monitor
  // ------------------------------------------------------------------
  always @(posedge clk_sys_in) vq <= op_valid;
  always @(negedge clk_sys_in) begin
    if (vq === 1'b1 && dq.size() != 0) chk_dec(dq.pop_front(), dec);
    if (pready === 1'b1 && aq.size() != 0) begin
      a = aq.pop_front();
      chk("pslverr", 32'(a.err), 32'(pslverr));
      if (a.chk_d) chk("prdata", a.d, prdata);
      if (st_rd) chk("status", 32'(dec_hold), prdata);
    end
    dec_hold = dec;
  end

  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    repeat (6000) @(posedge clk_sys_in);
    mismatches++;
    end_of_test();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {rst_in, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {seed, ctrl, count_exp, mismatches, tests_run} = {32'h42FD, 2'h3, 32'h0, 64'h0};
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(negedge clk_sys_in);
    chk("dec_reset", 32'h0, 32'(dec));
    apb(1'b0, 8'h00, 32'h0, '{1'b1, 1'b0, 32'h3});
    apb(1'b1, 8'h0C, 32'h0, '{1'b0, 1'b1, 32'h0});
    apb(1'b0, 8'h0C, 32'h0, '{1'b1, 1'b1, 32'h0});
    $display("test registers done");
    for (int i = 0; i < 256; i++) send({4'h5, i[7:4], 8'hC8}, i[3:0]);
    for (int i = 0; i < 16; i++) send({4'h6, i[3:0], 8'h00}, i[3:0] ^ 4'h6);
    for (int i = 0; i < 4; i++) send({12'hF08, i[3:0]}, 4'hF);
    drain();
    $display("test conditions done");
    foreach (fw[i]) send(fw[i], 4'h5);
    for (int i = 0; i < 200; i++) begin
      r = xs();
      send(r[15:0], r[19:16]);
    end
    drain();
    $display("test fields done");
    apb(1'b0, 8'h04, 32'h0, '{1'b0, 1'b0, 32'h0});
    apb(1'b0, 8'h08, 32'h0, '{1'b1, 1'b0, count_exp});
    apb(1'b1, 8'h00, 32'h0, '{1'b0, 1'b0, 32'h0});
    ctrl = 2'h0;
    for (int i = 0; i < 20; i++) begin
      r = xs();
      send(r[15:0] | 16'hF000, r[19:16]);
    end
    drain();
    apb(1'b0, 8'h08, 32'h0, '{1'b1, 1'b0, count_exp});
    apb(1'b1, 8'h08, 32'h0, '{1'b0, 1'b0, 32'h0});
    count_exp = 32'h0;
    apb(1'b0, 8'h08, 32'h0, '{1'b1, 1'b0, 32'h0});
    $display("test control done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
